// [src/cvt_unit.sv]
/*
  Package and top module of the conversion and table move unit: accumulator
  operations of a controller CPU (gray decode, digit shuffle, octal address
  load, label source load) and block copies inside variable memory and
  between variable memory and the data label area.
  Assumes the CPU core presents the accumulator and stack levels as plain
  words with a one-cycle operation strobe, and writes back acc_o on acc_we_o.
*/
// Behaviour
// - Gray decode takes 16-bit accumulator gray value
// - Result in low 10 bits, upper 22 zero
// - Direct result only for decoded values 0-399; higher BCD digits are cut off
// - Shuffle rearranges up to 8 digits into accumulator
// - Order digit 1-8 names destination position
// - Order digit 0 or 9-F drops digit
// - Duplicate destinations: most significant occurrence wins
// - Table move copies count words to operand address
// - Octal address operand converted to hex accumulator
// - Cartridge copy moves words either direction
// - Cartridge copy destination comes from operand
package cvt_pkg;
  localparam int ACC_W    = 32;
  localparam int WORD_W   = 16;
  localparam int DIG_W    = 4;
  localparam int DIG_N    = 8;
  localparam int GRAY_W   = 16;
  localparam int BCD_W    = 20;
  localparam int BCD_KEEP = 10;
  localparam int OCT_N    = 4;
  localparam int OCT_W    = 3;
  localparam int VM_AW    = 12;
  localparam int LBL_AW   = 10;

  localparam logic [ACC_W-1:0]  ACC_RST  = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  typedef enum logic [2:0] {
    gray_decode_op          = 3'h0,
    digit_shuffle_op        = 3'h1,
    table_move_op           = 3'h2,
    cartridge_block_copy_op = 3'h3,
    label_source_load_op    = 3'h4,
    octal_address_load_op   = 3'h5
  } cvt_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD   = 3'b010,
    ST_WR   = 3'b100
  } cvt_state_t;

  localparam logic SPACE_VM  = 1'b0;
  localparam logic SPACE_LBL = 1'b1;
endpackage

module cvt_unit #(
  parameter int VM_AW  = cvt_pkg::VM_AW,
  parameter int LBL_AW = cvt_pkg::LBL_AW
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  // Operation request from the CPU core
  input  wire logic                       op_valid_i,
  input  wire cvt_pkg::cvt_op_t           op_code_i,
  input  wire logic [cvt_pkg::ACC_W-1:0]  acc_i,
  input  wire logic [cvt_pkg::ACC_W-1:0]  stk1_i,
  input  wire logic [cvt_pkg::ACC_W-1:0]  stk2_i,
  input  wire logic [cvt_pkg::WORD_W-1:0] operand_i,
  // Result to the CPU core
  output logic      [cvt_pkg::ACC_W-1:0]  acc_o,
  output logic                            acc_we_o,
  output logic                            done_o,
  output logic                            busy_o,
  // Host access to the two memories
  input  wire logic                       host_space_i,
  input  wire logic [cvt_pkg::WORD_W-1:0] host_addr_i,
  input  wire logic [cvt_pkg::WORD_W-1:0] host_wdata_i,
  input  wire logic                       host_we_i,
  output logic      [cvt_pkg::WORD_W-1:0] host_rdata_o
);
  import cvt_pkg::*;

  cvt_state_t        state;
  cvt_state_t        next_state;
  logic              label_src;
  logic              from_label;
  logic              to_label;
  logic [WORD_W-1:0] src_base;
  logic [WORD_W-1:0] dst_base;
  logic [WORD_W-1:0] count;
  logic [WORD_W-1:0] idx;
  logic [WORD_W-1:0] cur_src;
  logic [WORD_W-1:0] cur_dst;
  logic              host_space_q;

  logic              start;
  logic              is_copy;
  logic [WORD_W-1:0] start_count;
  logic              last_word;

  logic [ACC_W-1:0]  gray_res;
  logic [BCD_W-1:0]  gray_bcd;
  logic [ACC_W-1:0]  shuf_res;
  logic [ACC_W-1:0]  oct_res;

  logic              vm_we;
  logic [VM_AW-1:0]  vm_waddr;
  logic [VM_AW-1:0]  vm_raddr;
  logic [WORD_W-1:0] vm_wdata;
  logic [WORD_W-1:0] vm_rdata;
  logic              lbl_we;
  logic [LBL_AW-1:0] lbl_waddr;
  logic [LBL_AW-1:0] lbl_raddr;
  logic [WORD_W-1:0] lbl_wdata;
  logic [WORD_W-1:0] lbl_rdata;
  logic [WORD_W-1:0] copy_data;

  function automatic logic [GRAY_W-1:0] gray_to_bin(input logic [GRAY_W-1:0] g);
    logic [GRAY_W-1:0] b;
    b = '0;
    b[GRAY_W-1] = g[GRAY_W-1];
    for (int i = GRAY_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Shift-and-add-three; combinational, one cycle is ample at this clock
  function automatic logic [BCD_W-1:0] bin_to_bcd(input logic [GRAY_W-1:0] b);
    logic [BCD_W-1:0] d;
    d = '0;
    for (int i = GRAY_W - 1; i >= 0; i--) begin
      for (int k = 0; k < BCD_W / DIG_W; k++) begin
        if (d[DIG_W*k +: DIG_W] >= 4'h5) begin
          d[DIG_W*k +: DIG_W] = d[DIG_W*k +: DIG_W] + 4'h3;
        end
      end
      d = {d[BCD_W-2:0], b[i]};
    end
    return d;
  endfunction

  // Later (more significant) source digits overwrite earlier ones
  function automatic logic [DIG_W-1:0] pick_digit(input logic [ACC_W-1:0] order,
                                                  input logic [ACC_W-1:0] src,
                                                  input logic [DIG_W-1:0] pos);
    logic [DIG_W-1:0] r;
    r = '0;
    for (int i = 0; i < DIG_N; i++) begin
      if (order[DIG_W*i +: DIG_W] == pos) begin
        r = src[DIG_W*i +: DIG_W];
      end
    end
    return r;
  endfunction

  // Gray decode; wide BCD cut to the ten kept bits
  always_comb begin
    gray_bcd = bin_to_bcd(gray_to_bin(acc_i[GRAY_W-1:0]));
    gray_res = '0;
    gray_res[BCD_KEEP-1:0] = gray_bcd[BCD_KEEP-1:0];
  end

  // One shuffle slice per result digit
  for (genvar p = 0; p < DIG_N; p++) begin : g_shuf
    assign shuf_res[DIG_W*p +: DIG_W] = pick_digit(acc_i, stk1_i, DIG_W'(p + 1));
  end

  // Octal digits in nibbles pack to three bits each
  always_comb begin
    oct_res = '0;
    for (int i = 0; i < OCT_N; i++) begin
      oct_res[OCT_W*i +: OCT_W] = operand_i[DIG_W*i +: OCT_W];
    end
  end

  assign start   = op_valid_i && (state == ST_IDLE);
  assign is_copy = (op_code_i == table_move_op) || (op_code_i == cartridge_block_copy_op);

  always_comb begin
    start_count = stk1_i[WORD_W-1:0];
    if (op_code_i == cartridge_block_copy_op) begin
      start_count = stk2_i[WORD_W-1:0];
    end
  end

  assign last_word = (idx == count - 16'h0001);
  assign cur_src   = src_base + idx;
  assign cur_dst   = dst_base + idx;
  assign copy_data = from_label ? lbl_rdata : vm_rdata;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start && is_copy && (start_count != WORD_RST)) begin
          next_state = ST_RD;
        end
      end
      ST_RD: begin
        next_state = ST_WR;
      end
      ST_WR: begin
        next_state = last_word ? ST_IDLE : ST_RD;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Copy set-up; offset added to both ends of a cartridge copy
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      src_base   <= WORD_RST;
      dst_base   <= WORD_RST;
      count      <= WORD_RST;
      from_label <= 1'b0;
      to_label   <= 1'b0;
    end else if (start && is_copy) begin
      count <= start_count;
      if (op_code_i == table_move_op) begin
        src_base   <= acc_i[WORD_W-1:0];
        dst_base   <= operand_i;
        from_label <= 1'b0;
        to_label   <= 1'b0;
      end else begin
        src_base   <= acc_i[WORD_W-1:0] + stk1_i[WORD_W-1:0];
        dst_base   <= operand_i + stk1_i[WORD_W-1:0];
        from_label <= label_src;
        to_label   <= !label_src;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      idx <= WORD_RST;
    end else if (state == ST_IDLE) begin
      idx <= WORD_RST;
    end else if (state == ST_WR) begin
      idx <= idx + 16'h0001;
    end
  end

  // Source kind remembered from the last started op of any kind; any other op forgets it
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      label_src <= 1'b0;
    end else if (start) begin
      label_src <= (op_code_i == label_source_load_op);
    end
  end

  // Memory ports: engine owns them while busy, host only when idle
  always_comb begin
    vm_raddr  = host_addr_i[VM_AW-1:0];
    lbl_raddr = host_addr_i[LBL_AW-1:0];
    vm_we     = (state == ST_IDLE) && host_we_i && (host_space_i == SPACE_VM);
    lbl_we    = (state == ST_IDLE) && host_we_i && (host_space_i == SPACE_LBL);
    vm_waddr  = host_addr_i[VM_AW-1:0];
    lbl_waddr = host_addr_i[LBL_AW-1:0];
    vm_wdata  = host_wdata_i;
    lbl_wdata = host_wdata_i;
    if (state != ST_IDLE) begin
      vm_raddr  = cur_src[VM_AW-1:0];
      lbl_raddr = cur_src[LBL_AW-1:0];
      vm_we     = (state == ST_WR) && !to_label;
      lbl_we    = (state == ST_WR) && to_label;
      vm_waddr  = cur_dst[VM_AW-1:0];
      lbl_waddr = cur_dst[LBL_AW-1:0];
      vm_wdata  = copy_data;
      lbl_wdata = copy_data;
    end
  end

  cvt_mem #(
    .AW (VM_AW),
    .DW (WORD_W)
  ) u_vmem (
    .clk_i   (clk_i),
    .we_i    (vm_we),
    .waddr_i (vm_waddr),
    .wdata_i (vm_wdata),
    .raddr_i (vm_raddr),
    .rdata_o (vm_rdata)
  );

  cvt_mem #(
    .AW (LBL_AW),
    .DW (WORD_W)
  ) u_lblmem (
    .clk_i   (clk_i),
    .we_i    (lbl_we),
    .waddr_i (lbl_waddr),
    .wdata_i (lbl_wdata),
    .raddr_i (lbl_raddr),
    .rdata_o (lbl_rdata)
  );

  // Accumulator results for the single-cycle ops
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      acc_o    <= ACC_RST;
      acc_we_o <= 1'b0;
    end else begin
      acc_we_o <= start && !is_copy;
      if (start) begin
        unique case (op_code_i)
          gray_decode_op:          acc_o <= gray_res;
          digit_shuffle_op:        acc_o <= shuf_res;
          octal_address_load_op:   acc_o <= oct_res;
          label_source_load_op:    acc_o <= {{(ACC_W-WORD_W){1'b0}}, operand_i};
          default:                 acc_o <= acc_o;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= (start && (!is_copy || (start_count == WORD_RST)))
                || ((state == ST_WR) && last_word);
      busy_o <= (next_state != ST_IDLE);
    end
  end

  // Host read data two clocks after the address
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      host_space_q <= SPACE_VM;
      host_rdata_o <= WORD_RST;
    end else begin
      host_space_q <= host_space_i;
      host_rdata_o <= (host_space_q == SPACE_LBL) ? lbl_rdata : vm_rdata;
    end
  end

endmodule

// [src/cvt_mem.sv]
/*
  Word memory for the conversion and table move unit: one write port and one
  read port, read data returned from a register one clock after the address.
  Assumes a single clock and that the user never reads and writes the same
  word in one cycle when the new value matters (read-before-write is returned).
*/
module cvt_mem #(
  parameter int AW = 12,
  parameter int DW = 16
) (
  // Clock
  input  wire logic          clk_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // Read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [2**AW];

  // No reset on the array: contents are program data, loaded by the host
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem[raddr_i];
  end

endmodule

// [bench/cvt_unit_checker.sv]
/*
  Checker for cvt_unit: result timing and values at the top ports.
  Assumes one clock and the synchronous active-low reset.
*/
module cvt_checker
  import cvt_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_b_i,
  input wire logic             op_valid_i,
  input wire cvt_pkg::cvt_op_t op_code_i,
  input wire logic [31:0]      acc_i,
  input wire logic [31:0]      stk1_i,
  input wire logic [15:0]      operand_i,
  input wire logic [31:0]      acc_o,
  input wire logic             acc_we_o,
  input wire logic             done_o,
  input wire logic             busy_o
);
  logic        take;
  logic        copy_go;
  logic [15:0] opd_q;
  assign take = op_valid_i && !busy_o && !copy_go;
  // A copy start also blocks the following edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) copy_go <= 1'b0;
    else copy_go <= take && (op_code_i inside {table_move_op, cartridge_block_copy_op});
  end
  always_ff @(posedge clk_i) opd_q <= operand_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_single;
    take && (op_code_i inside {gray_decode_op, digit_shuffle_op, label_source_load_op,
                               octal_address_load_op});
  endsequence
  sequence s_two_words;
    busy_o [*4] ##1 (done_o && !busy_o);
  endsequence
  single_result_a: assert property (s_single |=> acc_we_o && done_o)
    else $error("single op gave no result pulse");
  gray_upper_a: assert property (
    take && op_code_i == gray_decode_op |=> acc_o[31:10] == 22'h00_0000)
    else $error("gray result upper bits set");
  shuffle_drop_a: assert property (
    take && op_code_i == digit_shuffle_op && acc_i == 32'h0000_0000 |=> acc_o == 32'h0000_0000)
    else $error("dropped digits not zero");
  octal_load_a: assert property (take && op_code_i == octal_address_load_op |=>
    acc_o == {20'h0_0000, opd_q[14:12], opd_q[10:8], opd_q[6:4], opd_q[2:0]})
    else $error("octal load value wrong");
  label_load_a: assert property (
    take && op_code_i == label_source_load_op |=> acc_o == {16'h0000, opd_q})
    else $error("label load value wrong");
  copy_quiet_a: assert property (busy_o |-> !acc_we_o)
    else $error("accumulator written during copy");
  done_fall_a: assert property ($fell(busy_o) |-> done_o)
    else $error("busy fell without done");
  table_two_a: assert property (
    take && op_code_i == table_move_op && stk1_i[15:0] == 16'h0002 |=> s_two_words)
    else $error("two word move timing wrong");
  zero_count_a: assert property (
    take && op_code_i == table_move_op && stk1_i[15:0] == 16'h0000 |=> done_o && !busy_o)
    else $error("empty move timing wrong");
endmodule

// [bench/tb.sv]
/*
  Self-checking bench for cvt_unit: accumulator ops and block copies.
  Assumes the checker is compiled first; memories are seen via the host port.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cvt_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        op_valid_i = 1'b0;
  cvt_op_t     op_code_i = gray_decode_op;
  logic [31:0] acc_i = 32'h0000_0000;
  logic [31:0] stk1_i = 32'h0000_0000;
  logic [31:0] stk2_i = 32'h0000_0000;
  logic [15:0] operand_i = 16'h0000;
  logic        host_space_i = 1'b0;
  logic [15:0] host_addr_i = 16'h0000;
  logic [15:0] host_wdata_i = 16'h0000;
  logic        host_we_i = 1'b0;
  logic [31:0] acc_o;
  logic        acc_we_o;
  logic        done_o;
  logic        busy_o;
  logic [15:0] host_rdata_o;
  logic [15:0] mem_m [2][64];
  int          failures = 0;
  int          checked = 0;
  always #25 clk_i = ~clk_i;
  cvt_unit i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
    .acc_i(acc_i), .stk1_i(stk1_i), .stk2_i(stk2_i), .operand_i(operand_i),
    .acc_o(acc_o), .acc_we_o(acc_we_o), .done_o(done_o), .busy_o(busy_o),
    .host_space_i(host_space_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .host_we_i(host_we_i), .host_rdata_o(host_rdata_o)
  );
  task automatic report_and_stop;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_acc(logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic cmp_word(logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask
  // Idle cycle after each op keeps op_valid_i to one change per step
  task automatic run_op(cvt_op_t op, logic [31:0] a, s1, s2, logic [15:0] opd);
    op_code_i = op;
    acc_i = a;
    stk1_i = s1;
    stk2_i = s2;
    operand_i = opd;
    op_valid_i = 1'b1;
    step();
    op_valid_i = 1'b0;
    for (int n = 0; n < 40 && done_o !== 1'b1; n++) step();
    if (done_o !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    step();
  endtask
  task automatic check_mem;
    for (int i = 0; i < 128; i++) begin
      host_space_i = i[6];
      host_addr_i = 16'(i[5:0]);
      step();
      step();
      cmp_word(mem_m[i[6]][i[5:0]], host_rdata_o);
    end
  endtask
  function automatic logic [31:0] gray_exp(logic [15:0] g);
    logic [15:0] b;
    logic [19:0] d;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--) b[i] = b[i + 1] ^ g[i];
    for (int k = 0; k < 5; k++) begin
      d[4 * k +: 4] = 4'(b % 10);
      b = b / 10;
    end
    return {22'h00_0000, d[9:0]};
  endfunction
  // Ascending source order lets the upper duplicate overwrite
  function automatic logic [31:0] shuf_exp(logic [31:0] src, ord);
    logic [31:0] r;
    logic [3:0]  d;
    r = 32'h0000_0000;
    for (int i = 0; i < 8; i++) begin
      d = ord[4 * i +: 4];
      if (d >= 1 && d <= 8) r[4 * (d - 1) +: 4] = src[4 * i +: 4];
    end
    return r;
  endfunction
  initial begin
    logic [15:0] b;
    logic [15:0] p;
    logic [31:0] s;
    logic [31:0] o;
    logic [31:0] n;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] off;
    int          sp;
    void'($urandom(86));
    repeat (2) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    for (int t = 0; t < 24; t++) begin
      b = (t == 0) ? 16'h03FF : (t == 1) ? 16'h004C : (t == 2) ? 16'h0098 :
          (t < 12) ? 16'($urandom_range(0, 1023)) : 16'($urandom);
      run_op(gray_decode_op, {16'($urandom), b ^ (b >> 1)}, $urandom, $urandom, 16'($urandom));
      cmp_acc(gray_exp(b ^ (b >> 1)), acc_o);
      if (t == 1) cmp_acc(32'h0000_0000, acc_o - 32'h0000_0076);
      if (t == 2) cmp_acc(32'h0000_0000, acc_o - 32'h0000_0152);
      s = (t == 0) ? 32'h9ABC_DEF0 : $urandom;
      o = (t == 0) ? 32'h1287_3654 : (t == 1) ? 32'h1111_1111 : (t < 3) ? 32'h0 : $urandom;
      run_op(digit_shuffle_op, o, s, $urandom, 16'($urandom));
      cmp_acc(shuf_exp(s, o), acc_o);
      p = (t == 0) ? 16'h2000 : 16'($urandom) & 16'h7777;
      run_op(octal_address_load_op, $urandom, $urandom, $urandom, p);
      cmp_acc({20'h0_0000, p[14:12], p[10:8], p[6:4], p[2:0]}, acc_o);
    end
    $display("test accumulator ops done");
    host_we_i = 1'b1;
    for (int i = 0; i < 128; i++) begin
      host_space_i = i[6];
      host_addr_i = 16'(i[5:0]);
      host_wdata_i = 16'($urandom);
      mem_m[i[6]][i[5:0]] = host_wdata_i;
      step();
    end
    host_we_i = 1'b0;
    for (int t = 0; t < 9; t++) begin
      n = (t == 0) ? 0 : (t == 3) ? 2 : $urandom_range(1, 8);
      src = $urandom_range(0, 47);
      dst = $urandom_range(0, 47);
      off = $urandom_range(0, 7);
      sp = t % 3;
      if (sp == 0) begin
        run_op(table_move_op, src, n, $urandom, 16'(dst));
        for (int k = 0; k < n; k++) mem_m[0][dst + k] = mem_m[0][src + k];
      end else begin
        if (sp == 1) begin
          run_op(label_source_load_op, $urandom, $urandom, $urandom, 16'(src));
          cmp_acc(src, acc_o);
        end
        run_op(cartridge_block_copy_op, src, off, n, 16'(dst));
        for (int k = 0; k < n; k++) mem_m[sp - 1][dst + off + k] = mem_m[2 - sp][src + off + k];
      end
      check_mem();
    end
    $display("test block copies done");
    report_and_stop();
  end
endmodule
bind cvt_unit cvt_checker i_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
  .acc_i(acc_i), .stk1_i(stk1_i), .operand_i(operand_i), .acc_o(acc_o),
  .acc_we_o(acc_we_o), .done_o(done_o), .busy_o(busy_o)
);
